/* File: design/emb_bus_if.sv */
// External slave bus engine: SDRAM, chip selects, ISA strobes and buffer steering
`timescale 1ns/100ps
module emb_bus_if
  import emb_pkg::*;
#(
  parameter int ASYNC_CYC = EMB_ASYNC_CYC,
  parameter int ISA_CYC   = EMB_ISA_MIN_CYC
)
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  boot_internal,
  input  wire logic                  req_valid,
  input  wire emb_req_type           req,
  output logic                       req_ready,
  output logic                       done,
  output logic [EMB_DATA_W-1:0]      rdata,
  output logic                       rom_select,
  output logic [EMB_PIN_ADDR_HI:EMB_PIN_ADDR_LO] addr_pins,
  output logic                       read_write,
  output logic                       output_en_n,
  input  wire logic [EMB_DATA_W-1:0] data_in,
  output logic [EMB_DATA_W-1:0]      data_out,
  output logic                       data_oe,
  output logic                       sdram_row_strobe_n,
  output logic                       sdram_col_strobe_n,
  output logic                       sdram_write_en_n,
  output logic                       sdram_chip_en_n,
  output logic                       sdram_upper_mask,
  output logic                       sdram_lower_mask,
  output logic                       bus_clock_en,
  output logic                       boot_select_n,
  output logic                       second_select_n,
  output logic                       isa_select_n,
  output logic                       isa_read_strobe_n,
  output logic                       isa_write_strobe_n,
  input  wire logic                  isa_ready_in,
  output logic                       buffer_enable_one,
  output logic                       buffer_enable_two
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ROW, ST_COL, ST_CAS, ST_ASYNC, ST_ISA, ST_ISA_WAIT, ST_END
  } emb_state_type;

  emb_state_type            state_reg;
  emb_target_type           target;
  emb_target_type           tgt_reg;
  emb_req_type              req_reg;
  logic [EMB_CNT_W-1:0]     cnt_reg;
  logic                     ready_meta_reg;
  logic                     ready_sync_reg;
  logic                     boot_meta_reg;
  logic                     boot_mode_reg;
  logic                     cs_act;

  // Phases in which a chip-select target is being addressed
  assign cs_act = state_reg == ST_ASYNC || state_reg == ST_ISA || state_reg == ST_ISA_WAIT ||
                  (state_reg == ST_ADDR && tgt_reg != EMB_TGT_SDRAM);

  emb_decode u_decode (
    .addr          (req.addr),
    .boot_internal (boot_mode_reg),
    .target        (target)
  );

  function automatic logic [1:0] emb_masks(input logic [1:0] size, input logic a0);
    // Byte operand masks the unused lane; wider operands enable both
    if (size == 2'h0) begin
      emb_masks = a0 ? 2'h2 : 2'h1;
    end else begin
      emb_masks = 2'h0;
    end
  endfunction : emb_masks

  function automatic logic [EMB_PIN_ADDR_HI:EMB_PIN_ADDR_LO] emb_pin_addr(
    input logic [EMB_ADDR_W-1:0] a, input logic sd);
    logic [EMB_PIN_ADDR_HI:EMB_PIN_ADDR_LO] p;
    p = a[EMB_PIN_ADDR_HI:EMB_PIN_ADDR_LO];
    if (sd) begin
      p[EMB_BIT_SHARED] = a[EMB_BIT_EXTRA];
    end
    emb_pin_addr = p;
  endfunction : emb_pin_addr

  // Boot strap synchronised, then captured only while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_meta_reg <= 1'b0;
      boot_mode_reg <= 1'b0;
    end else begin
      boot_meta_reg <= boot_internal;
      if (state_reg == ST_IDLE && !req_valid) begin
        boot_mode_reg <= boot_meta_reg;
      end
    end
  end

  // Ready input synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_meta_reg <= 1'b1;
      ready_sync_reg <= 1'b1;
    end else begin
      ready_meta_reg <= isa_ready_in;
      ready_sync_reg <= ready_meta_reg;
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      tgt_reg   <= EMB_TGT_DEFAULT;
      req_reg   <= '0;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (req_valid) begin
            req_reg   <= req;
            tgt_reg   <= target;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          cnt_reg <= '0;
          case (tgt_reg)
            EMB_TGT_SDRAM: state_reg <= ST_ROW;
            EMB_TGT_ISA:   state_reg <= ST_ISA;
            default:       state_reg <= ST_ASYNC;
          endcase
        end
        ST_ROW: state_reg <= ST_COL;
        ST_COL: begin
          cnt_reg   <= '0;
          state_reg <= req_reg.write ? ST_END : ST_CAS;
        end
        ST_CAS: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == EMB_CNT_W'(EMB_CAS_LAT - 1)) begin
            state_reg <= ST_END;
          end
        end
        ST_ASYNC: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == EMB_CNT_W'(ASYNC_CYC - 1)) begin
            state_reg <= ST_END;
          end
        end
        ST_ISA: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == EMB_CNT_W'(ISA_CYC - 1)) begin
            state_reg <= ST_ISA_WAIT;
          end
        end
        ST_ISA_WAIT: begin
          if (ready_sync_reg) begin
            state_reg <= ST_END;
          end
        end
        ST_END:  state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Read data capture and completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!req_reg.write && ((state_reg == ST_CAS && cnt_reg == EMB_CNT_W'(EMB_CAS_LAT - 1)) ||
          (state_reg == ST_ASYNC && cnt_reg == EMB_CNT_W'(ASYNC_CYC - 1)) ||
          (state_reg == ST_ISA_WAIT && ready_sync_reg))) begin
        rdata <= data_in;
      end
      if (state_reg == ST_END) begin
        done <= 1'b1;
      end
    end
  end

  // Address, direction and data drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready   <= 1'b0;
      addr_pins   <= '0;
      read_write  <= 1'b1;
      output_en_n <= 1'b1;
      data_out    <= '0;
      data_oe     <= 1'b0;
    end else begin
      req_ready <= (state_reg == ST_IDLE) && !req_valid;
      if (state_reg == ST_IDLE && req_valid) begin
        addr_pins  <= emb_pin_addr(req.addr, target == EMB_TGT_SDRAM);
        read_write <= !req.write;
      end else if (state_reg == ST_ROW) begin
        addr_pins <= (EMB_PIN_ADDR_HI - EMB_PIN_ADDR_LO + 1)'(
                     req_reg.addr[EMB_COL_W:EMB_PIN_ADDR_LO]);
      end else if (state_reg == ST_END) begin
        read_write <= 1'b1;
      end
      output_en_n <= !(!req_reg.write && (state_reg == ST_ASYNC || state_reg == ST_ISA ||
                       state_reg == ST_ISA_WAIT));
      data_out    <= req_reg.wdata;
      data_oe     <= req_reg.write && state_reg != ST_IDLE && state_reg != ST_END &&
                     state_reg != ST_ADDR;
    end
  end

  // SDRAM command pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sdram_chip_en_n, sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n} <= EMB_CMD_NOP;
      sdram_upper_mask <= 1'b1;
      sdram_lower_mask <= 1'b1;
      bus_clock_en     <= 1'b0;
    end else begin
      bus_clock_en       <= 1'b1;
      sdram_chip_en_n    <= !(state_reg == ST_ADDR && tgt_reg == EMB_TGT_SDRAM) &&
                            state_reg != ST_ROW;
      sdram_row_strobe_n <= !(state_reg == ST_ADDR && tgt_reg == EMB_TGT_SDRAM);
      sdram_col_strobe_n <= state_reg != ST_ROW;
      sdram_write_en_n   <= !(state_reg == ST_ROW && req_reg.write);
      {sdram_upper_mask, sdram_lower_mask} <= (tgt_reg == EMB_TGT_SDRAM &&
        state_reg != ST_IDLE) ? emb_masks(req_reg.size, req_reg.addr[0]) : 2'h3;
    end
  end

  // Chip selects, ISA strobes and internal ROM select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_select_n      <= 1'b1;
      second_select_n    <= 1'b1;
      isa_select_n       <= 1'b1;
      isa_read_strobe_n  <= 1'b1;
      isa_write_strobe_n <= 1'b1;
      rom_select         <= 1'b0;
    end else begin
      // Pin shows boot select or, in internal boot, the alternate select
      boot_select_n      <= !(cs_act && (tgt_reg == EMB_TGT_BOOT ||
                              tgt_reg == EMB_TGT_ALT));
      rom_select         <= cs_act && boot_mode_reg &&
                            req_reg.addr[EMB_ADDR_W-1:EMB_REGION_SHIFT] ==
                            EMB_BOOT_BASE[EMB_ADDR_W-1:EMB_REGION_SHIFT];
      second_select_n    <= !(cs_act && tgt_reg == EMB_TGT_SECOND);
      isa_select_n       <= !(cs_act && tgt_reg == EMB_TGT_ISA);
      isa_read_strobe_n  <= !((state_reg == ST_ISA || (state_reg == ST_ISA_WAIT &&
                              !ready_sync_reg)) && !req_reg.write);
      isa_write_strobe_n <= !((state_reg == ST_ISA || (state_reg == ST_ISA_WAIT &&
                              !ready_sync_reg)) && req_reg.write);
    end
  end

  // Bus buffer steering
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_enable_one <= 1'b0;
      buffer_enable_two <= 1'b0;
    end else begin
      buffer_enable_one <= (state_reg == ST_ASYNC) &&
                           (tgt_reg == EMB_TGT_BOOT || tgt_reg == EMB_TGT_SECOND ||
                            tgt_reg == EMB_TGT_ALT);
      buffer_enable_two <= (state_reg == ST_ISA || state_reg == ST_ISA_WAIT);
    end
  end
endmodule : emb_bus_if

/* File: design/emb_pkg.sv */
// Package of constants and carrier types for the external memory bus interface
package emb_pkg;
  localparam int          EMB_ADDR_W        = 25;
  localparam int          EMB_DATA_W        = 16;
  localparam int          EMB_ROW_W         = 13;
  localparam int          EMB_COL_W         = 10;
  localparam int          EMB_PIN_ADDR_HI   = 23;
  localparam int          EMB_PIN_ADDR_LO   = 1;
  localparam int          EMB_BIT_SHARED    = 20;
  localparam int          EMB_BIT_EXTRA     = 24;
  localparam logic [25:0] EMB_SDRAM_LIMIT   = 26'h2000000;
  localparam logic [24:0] EMB_SDRAM_BASE    = 25'h0000000;
  localparam logic [24:0] EMB_BOOT_BASE     = 25'h1000000;
  localparam logic [24:0] EMB_SECOND_BASE   = 25'h1400000;
  localparam logic [24:0] EMB_ISA_BASE      = 25'h1800000;
  localparam logic [24:0] EMB_ALT_BASE      = 25'h1C00000;
  localparam int          EMB_REGION_SHIFT  = 22;
  localparam int          EMB_CLK_MHZ       = 40;
  localparam int          EMB_ASYNC_NS      = 75;
  localparam int          EMB_ASYNC_CYC     = (EMB_ASYNC_NS * EMB_CLK_MHZ + 999) / 1000;
  localparam int          EMB_ISA_MIN_NS    = 100;
  localparam int          EMB_ISA_MIN_CYC   = (EMB_ISA_MIN_NS * EMB_CLK_MHZ + 999) / 1000;
  localparam int          EMB_CAS_LAT       = 2;
  localparam int          EMB_CNT_W         = 4;
  localparam logic [3:0]  EMB_CMD_NOP       = 4'h7;

  typedef enum logic [2:0] {
    EMB_TGT_DEFAULT,
    EMB_TGT_SDRAM,
    EMB_TGT_BOOT,
    EMB_TGT_SECOND,
    EMB_TGT_ISA,
    EMB_TGT_ALT
  } emb_target_type;

  typedef struct packed {
    logic                  write;
    logic [1:0]            size;
    logic [EMB_ADDR_W-1:0] addr;
    logic [EMB_DATA_W-1:0] wdata;
  } emb_req_type;

  typedef struct packed {
    logic boot_n;
    logic second_n;
    logic isa_n;
    logic sdram_n;
  } emb_sel_type;
endpackage : emb_pkg

/* File: design/emb_decode.sv */
// Address decoder choosing the target of an external access
`timescale 1ns/100ps
module emb_decode
  import emb_pkg::*;
(
  input  wire logic [EMB_ADDR_W-1:0] addr,
  input  wire logic                  boot_internal,
  output emb_target_type             target
);
  logic [2:0] region;
  always_comb begin
    region = 3'(addr >> EMB_REGION_SHIFT);
    target = EMB_TGT_DEFAULT;
    if ({1'b0, addr} < EMB_SDRAM_LIMIT &&
        addr[EMB_ADDR_W-1] == EMB_SDRAM_BASE[EMB_ADDR_W-1]) begin
      target = EMB_TGT_SDRAM;
    end else begin
      case (region)
        3'(EMB_BOOT_BASE >> EMB_REGION_SHIFT):   target = boot_internal ? EMB_TGT_DEFAULT
                                                                        : EMB_TGT_BOOT;
        3'(EMB_SECOND_BASE >> EMB_REGION_SHIFT): target = EMB_TGT_SECOND;
        3'(EMB_ISA_BASE >> EMB_REGION_SHIFT):    target = EMB_TGT_ISA;
        3'(EMB_ALT_BASE >> EMB_REGION_SHIFT):    target = boot_internal ? EMB_TGT_ALT
                                                                        : EMB_TGT_DEFAULT;
        default:                                 target = EMB_TGT_DEFAULT;
      endcase
    end
  end
endmodule : emb_decode

/* File: verification/emb_bus_if_assertions.sv */
// Checker of bus-cycle relations for the external bus engine
`timescale 1ns/100ps
module emb_bus_if_assertions
  import emb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic boot_internal,
  input wire logic done,
  input wire logic rom_select,
  input wire logic read_write,
  input wire logic output_en_n,
  input wire logic data_oe,
  input wire logic sdram_row_strobe_n,
  input wire logic sdram_col_strobe_n,
  input wire logic sdram_write_en_n,
  input wire logic sdram_chip_en_n,
  input wire logic bus_clock_en,
  input wire logic boot_select_n,
  input wire logic isa_select_n,
  input wire logic isa_read_strobe_n,
  input wire logic isa_ready_in
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_oe_read: assert property (!output_en_n |-> read_write)
    else $error("output enable low outside a read");
  chk_drive_write: assert property (data_oe |-> !read_write)
    else $error("data driven outside a write");
  chk_we_read: assert property (read_write |-> sdram_write_en_n)
    else $error("sdram write enable low in a read");
  chk_strobe_cs: assert property (
    !sdram_row_strobe_n || !sdram_col_strobe_n |-> !sdram_chip_en_n)
    else $error("sdram strobe without chip enable");
  chk_sel_excl: assert property (!sdram_chip_en_n |-> boot_select_n && isa_select_n)
    else $error("two targets selected");
  chk_isa_wait: assert property (
    !isa_read_strobe_n && !isa_ready_in && !$past(isa_ready_in)
    |=> !isa_read_strobe_n && !isa_select_n) else $error("isa strobe ended while not ready");
  chk_rom_ext: assert property (!boot_internal && !$past(boot_internal) |-> !rom_select)
    else $error("internal rom selected in external boot");
  chk_rom_pin: assert property (rom_select |-> boot_select_n)
    else $error("boot pin low during internal rom access");
  chk_clk_en: assert property ($past(rst_n) |-> bus_clock_en)
    else $error("clock enable low after reset");
  chk_wr_walk: assert property (
    !sdram_col_strobe_n && !sdram_write_en_n |-> data_oe ##2 done)
    else $error("sdram write walk broken");
  cover property (!isa_read_strobe_n && !isa_ready_in);
  cover property (rom_select);
  cover property (!sdram_col_strobe_n && sdram_write_en_n);
endmodule : emb_bus_if_assertions
bind emb_bus_if emb_bus_if_assertions emb_bus_if_assertions_inst (.clk, .rst_n, .boot_internal,
  .done, .rom_select, .read_write, .output_en_n, .data_oe, .sdram_row_strobe_n,
  .sdram_col_strobe_n, .sdram_write_en_n, .sdram_chip_en_n, .bus_clock_en, .boot_select_n,
  .isa_select_n, .isa_read_strobe_n, .isa_ready_in);

/* File: verification/emb_far_model.sv */
// Behavioural SDRAM, async memory and ISA peripheral on the far side of the bus
`timescale 1ns/100ps
module emb_far_model
  import emb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  isa_hold,
  input  wire logic [7:0]  addr_lo,
  input  wire logic        read_write,
  input  wire logic        output_en_n,
  input  wire logic        data_oe,
  input  wire logic [15:0] data_out,
  input  wire logic        sdram_chip_en_n,
  input  wire logic        sdram_col_strobe_n,
  input  wire logic        sdram_write_en_n,
  input  wire logic        boot_select_n,
  input  wire logic        second_select_n,
  input  wire logic        isa_read_strobe_n,
  input  wire logic        isa_write_strobe_n,
  output logic      [15:0] drive_data,
  output logic             isa_ready_in
);
  logic [15:0] mem [0:255];
  logic [7:0]  col_idx;
  logic [7:0]  wait_cnt;
  logic        rd_due;
  logic        sd_col;
  logic        isa_idle;
  logic        async_sel;
  assign sd_col       = !sdram_chip_en_n && !sdram_col_strobe_n;
  assign isa_idle     = isa_read_strobe_n && isa_write_strobe_n;
  assign async_sel    = !(boot_select_n && second_select_n);
  assign isa_ready_in = isa_idle || (wait_cnt == 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_due     <= 1'b0;
      drive_data <= 16'h0000;
    end else begin
      rd_due  <= sd_col && sdram_write_en_n;
      col_idx <= addr_lo;
      if (rd_due) begin
        drive_data <= mem[col_idx];
      end else if ((!output_en_n && async_sel) || !isa_read_strobe_n) begin
        drive_data <= mem[addr_lo];
      end else begin
        drive_data <= ~drive_data;
      end
    end
  end
  always_ff @(posedge clk) begin
    if ((sd_col && !sdram_write_en_n) || (data_oe && (async_sel || !isa_write_strobe_n))) begin
      mem[addr_lo] <= data_out;
    end
    if (isa_idle) begin
      wait_cnt <= isa_hold;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule : emb_far_model

/* File: verification/testbench.sv */
// Self-checking testbench for the external bus engine
`timescale 1ns/100ps
module testbench
  import emb_pkg::*;
;
  emb_req_type req;
  logic        clk, rst_n, boot_internal, req_valid, done, rom_select, um, lm;
  logic [15:0] rdata, data_in, data_out, drive_data, row_cap, col_cap, wd_cap;
  logic [23:1] addr_pins;
  logic        read_write, output_en_n, data_oe, sdram_row_strobe_n, sdram_col_strobe_n;
  logic        sdram_write_en_n, sdram_chip_en_n, sdram_upper_mask, sdram_lower_mask;
  logic        bus_clock_en, boot_select_n, second_select_n, isa_select_n, isa_ready_in;
  logic        isa_read_strobe_n, isa_write_strobe_n, saw_sd, saw_boot, saw_sec, saw_isa;
  logic        saw_rom, saw_oe, row20, saw_b1, saw_b2, req_ready, buffer_enable_one;
  logic        buffer_enable_two;
  logic [7:0]  isa_hold;
  int          error_cnt, check_count, isa_len, tick;
  always #12.5 clk = ~clk;
  assign data_in = data_oe ? data_out : drive_data;
  emb_bus_if #(.ASYNC_CYC(3), .ISA_CYC(4)) emb_bus_if_inst (.clk, .rst_n, .boot_internal,
    .req_valid, .req, .req_ready, .done, .rdata, .rom_select, .addr_pins, .read_write,
    .output_en_n, .data_in, .data_out, .data_oe, .sdram_row_strobe_n, .sdram_col_strobe_n,
    .sdram_write_en_n, .sdram_chip_en_n, .sdram_upper_mask, .sdram_lower_mask, .bus_clock_en,
    .boot_select_n, .second_select_n, .isa_select_n, .isa_read_strobe_n, .isa_write_strobe_n,
    .isa_ready_in, .buffer_enable_one, .buffer_enable_two);
  emb_far_model emb_far_model_inst (.clk, .rst_n, .isa_hold, .addr_lo(addr_pins[8:1]),
    .read_write, .output_en_n, .data_oe, .data_out, .sdram_chip_en_n, .sdram_col_strobe_n,
    .sdram_write_en_n, .boot_select_n, .second_select_n, .isa_read_strobe_n,
    .isa_write_strobe_n, .drive_data, .isa_ready_in);
  // Records what each access showed on the pins
  always @(posedge clk) begin
    tick++;
    saw_sd |= !sdram_chip_en_n;
    saw_boot |= !boot_select_n;
    saw_sec |= !second_select_n;
    saw_isa |= !isa_select_n;
    saw_rom |= rom_select;
    saw_oe |= !output_en_n;
    saw_b1 |= buffer_enable_one;
    saw_b2 |= buffer_enable_two;
    if (!sdram_row_strobe_n) begin
      row_cap = addr_pins[16:1];
      row20 = addr_pins[EMB_BIT_SHARED];
    end
    if (!sdram_col_strobe_n) begin
      col_cap = addr_pins[16:1];
      wd_cap = data_out;
      {um, lm} = {sdram_upper_mask, sdram_lower_mask};
    end
    if (!(isa_read_strobe_n && isa_write_strobe_n)) isa_len++;
    if (tick == 4000) begin
      error_cnt++;
      $display("BAD %0t run too long", $time);
      end_sim();
    end
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic access(input logic wr, input logic [1:0] sz, input logic [24:0] a,
                        input logic [15:0] wd, output logic [15:0] rd, output int cyc);
    {saw_sd, saw_boot, saw_sec, saw_isa, saw_rom, saw_oe, saw_b1, saw_b2} = 8'h00;
    isa_len = 0;
    req = '{write: wr, size: sz, addr: a, wdata: wd};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 80) begin
      @(negedge clk);
      cyc++;
    end
    rd = rdata;
    @(negedge clk);
  endtask : access
  task automatic t_reset;
    repeat (2) @(negedge clk);
    chk16({8'h00, boot_select_n, isa_select_n, isa_read_strobe_n, sdram_chip_en_n,
           sdram_row_strobe_n, read_write, bus_clock_en, data_oe}, 16'h00EC);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk1(bus_clock_en, 1'b1);
    chk1(req_ready, 1'b1);
  endtask : t_reset
  task automatic t_sdram;
    logic [15:0] rd;
    int          c;
    access(1'b1, 2'd1, 25'h0100104, 16'h1234, rd, c);
    chk16(16'(c), 16'd5);
    chk1(saw_sd, 1'b1);
    chk1(row20, 1'b0);
    chk1(saw_b1 | saw_b2, 1'b0);
    chk16(row_cap, 16'h0082);
    chk16({6'h00, col_cap[9:0]}, 16'h0082);
    access(1'b0, 2'd1, 25'h0100104, 16'h0000, rd, c);
    chk16(16'(c), 16'd7);
    chk16(rd, 16'h1234);
  endtask : t_sdram
  task automatic t_mask;
    logic [24:0] ad [3] = '{25'h0000107, 25'h0000106, 25'h0000108};
    logic [1:0]  sz [3] = '{2'd0, 2'd0, 2'd1};
    logic [1:0]  ex [3] = '{2'b10, 2'b01, 2'b00};
    logic [15:0] rd;
    int          c;
    for (int i = 0; i < 3; i++) begin
      access(1'b1, sz[i], ad[i], 16'hC3A5, rd, c);
      chk16({14'h0000, um, lm}, {14'h0000, ex[i]});
      chk16(wd_cap, 16'hC3A5);
    end
  endtask : t_mask
  task automatic t_async;
    logic [24:0] ad [2] = '{25'h1000010, 25'h1400020};
    logic [15:0] rd;
    int          c;
    for (int i = 0; i < 2; i++) begin
      access(1'b1, 2'd1, ad[i], 16'h6C00 + 16'(i), rd, c);
      chk1(i == 0 ? saw_boot : saw_sec, 1'b1);
      chk1(saw_b1, 1'b1);
      chk1(saw_b2, 1'b0);
      chk1(saw_oe, 1'b0);
      access(1'b0, 2'd1, ad[i], 16'h0000, rd, c);
      chk16(rd, 16'h6C00 + 16'(i));
      chk1(saw_oe, 1'b1);
      chk1(saw_rom, 1'b0);
    end
    access(1'b0, 2'd1, 25'h1C00030, 16'h0000, rd, c);
    chk16(16'(c), 16'd6);
    chk1(saw_boot | saw_sec | saw_isa | saw_sd, 1'b0);
  endtask : t_async
  task automatic t_boot_int;
    logic [15:0] rd;
    int          c;
    boot_internal = 1'b1;
    repeat (2) @(negedge clk);
    access(1'b0, 2'd1, 25'h1000010, 16'h0000, rd, c);
    chk1(saw_rom, 1'b1);
    chk1(saw_boot, 1'b0);
    access(1'b1, 2'd1, 25'h1C00030, 16'h7E81, rd, c);
    chk1(saw_boot, 1'b1);
    access(1'b0, 2'd1, 25'h1C00030, 16'h0000, rd, c);
    chk16(rd, 16'h7E81);
    boot_internal = 1'b0;
    repeat (2) @(negedge clk);
  endtask : t_boot_int
  task automatic t_isa;
    logic [15:0] rd;
    int          c;
    access(1'b1, 2'd1, 25'h1800040, 16'h5A3C, rd, c);
    chk1(saw_isa, 1'b1);
    chk1(saw_b2, 1'b1);
    chk1(saw_b1, 1'b0);
    isa_hold = 8'd10;
    access(1'b0, 2'd1, 25'h1800040, 16'h0000, rd, c);
    chk16(rd, 16'h5A3C);
    chk1(isa_len >= 10, 1'b1);
  endtask : t_isa
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    {clk, rst_n, boot_internal, req_valid} = 4'h0;
    req = '0;
    isa_hold = 8'h00;
    t_reset();
    t_sdram();
    t_mask();
    t_async();
    t_boot_int();
    t_isa();
    end_sim();
  end
endmodule : testbench
